// ===== fabric_requester.sv
// Fabric user logic: raises program or erase on go and holds it.
// Assumes busy is the block's registered busy flag on the same clock.
`timescale 1ns/1ps
module fabric_requester (
  input  wire clk,
  input  wire rst,
  input  wire busy,
  input  wire go,
  input  wire op_erase,
  output reg  program_req,
  output reg  erase_req
);
  reg seen_reg;
  always @(posedge clk) begin
    if (rst || (seen_reg && !busy)) begin
      program_req <= 1'b0;
      erase_req <= 1'b0;
      seen_reg <= 1'b0;
    end else if (go) begin
      program_req <= !op_erase;
      erase_req <= op_erase;
    end else if (busy) begin
      seen_reg <= 1'b1;
    end
  end
endmodule

// ===== flash_port_defs.vh
// Constants for the user flash serial port model.
// Assumes a 100 MHz system clock; included by the design files by bare name.
`ifndef FLASH_PORT_DEFS_VH
`define FLASH_PORT_DEFS_VH
`define ADDR_WIDTH        9
`define DATA_WIDTH        16
`define WORD_COUNT        512
`define OSC_DIVIDE        4
`define CLK_PERIOD_NS     10
`define OSC_PERIOD_NS     240
`define OSC_HALF_CYCLES   ((`OSC_PERIOD_NS / `CLK_PERIOD_NS) / 2)
`define PROG_TIME_NS      1600
`define PROG_CYCLES       (`PROG_TIME_NS / `CLK_PERIOD_NS)
`define ERASE_TIME_NS     3200
`define ERASE_CYCLES      (`ERASE_TIME_NS / `CLK_PERIOD_NS)
`define ERASED_WORD       16'hFFFF
`endif

// ===== osc_divider.v
// Internal oscillator of the flash block and its divide-by-four output.
// Assumes one system clock; the oscillator is modelled as a clock-enable tick.
`timescale 1ns/1ps
`include "flash_port_defs.vh"
module osc_divider #(
  parameter HALF_CYCLES = `OSC_HALF_CYCLES
) (
  input  wire clk,
  input  wire rst,
  input  wire ce,
  output reg  osc_tick,
  output reg  div_out
);
  // The oscillator runs four times faster than the divided output
  localparam TICK_CYCLES = HALF_CYCLES / 2;

  reg [7:0] count_reg;
  reg [1:0] div_reg;

  always @(posedge clk) begin
    if (rst) begin
      count_reg <= 8'h00;
      div_reg   <= 2'h0;
      osc_tick  <= 1'b0;
      div_out   <= 1'b0;
    end else if (ce) begin
      osc_tick <= 1'b0;
      if (count_reg == TICK_CYCLES[7:0] - 8'h01) begin
        count_reg <= 8'h00;
        osc_tick  <= 1'b1;
        div_reg   <= div_reg + 2'h1;
        div_out   <= div_reg[1] ^ div_reg[0];
      end else begin
        count_reg <= count_reg + 8'h01;
      end
    end
  end
endmodule

// ===== tb_user_flash_serial_port.sv
// Self-checking bench for the user flash serial port.
// Assumes the fabric requester model drives program and erase.
`timescale 1ns/1ps
module tb_user_flash_serial_port;
  reg         clk = 0, rst = 1, asel = 0, aclk = 0, ain = 0, dclk = 0, dsel = 0, din = 0;
  reg         go = 0, op = 0, tsel = 0, twr = 0, q = 0;
  reg  [8:0]  taddr = 9'h000;
  reg  [15:0] twd = 16'h0000, d;
  wire [15:0] trd;
  wire [8:0]  aout;
  wire        dout, busy, dosc, prog, era;
  integer     errors = 0, check_count = 0, i, n;
  user_flash_serial_port uut (.CLOCK(clk), .RST(rst), .CE(1'b1), .ADDRESS_SHIFT_SELECT(asel),
    .ADDRESS_SHIFT_CLOCK(aclk), .ADDRESS_IN(ain), .DATA_SHIFT_CLOCK(dclk),
    .DATA_SHIFT_SELECT(dsel), .DATA_IN(din), .PROGRAM(prog), .ERASE(era),
    .TEST_PORT_SELECT(tsel), .TEST_PORT_WRITE(twr), .TEST_PORT_ADDRESS(taddr),
    .TEST_PORT_WDATA(twd), .TEST_PORT_RDATA(trd), .DATA_OUT(dout), .BUSY(busy),
    .ADDRESS_OUT(aout), .DIVIDED_OSCILLATOR_OUT(dosc));
  fabric_requester fab (.clk(clk), .rst(rst), .busy(busy), .go(go), .op_erase(op),
    .program_req(prog), .erase_req(era));
  initial forever #5 clk = ~clk;
  task chk(input [15:0] got, input [15:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // One shift clock pulse; w picks the data side
  task pulse(input w, input s, input b);
    begin
      @(posedge clk);
      if (w) begin
        dsel <= s;
        din <= b;
        dclk <= 1'b1;
      end else begin
        asel <= s;
        ain <= b;
        aclk <= 1'b1;
      end
      @(posedge clk);
      aclk <= 1'b0;
      dclk <= 1'b0;
      @(posedge clk) #1;
    end
  endtask
  task load(input [8:0] a);
    for (i = 8; i >= 0; i = i - 1) pulse(0, 1, a[i]);
  endtask
  task rd(input ld, input [15:0] exp);
    begin
      if (ld) pulse(1, 0, 0);
      for (i = 15; i >= 0; i = i - 1) begin
        d[i] = dout;
        if (i > 0) pulse(1, 1, 0);
      end
      chk(d, exp);
    end
  endtask
  task request(input e);
    begin
      @(posedge clk) go <= 1'b1;
      op <= e;
      @(posedge clk) go <= 1'b0;
      for (n = 0; busy !== 1'b1 && n < 50; n = n + 1) @(posedge clk);
      #1 chk({15'h0000, busy}, 16'h0001);
      // Address stepping is refused while the erase runs
      if (e) pulse(0, 0, 0);
      if (e) chk({7'h00, aout}, 16'h00FF);
      for (n = 0; busy !== 1'b0 && n < 2000; n = n + 1) @(posedge clk);
      #1 chk({15'h0000, busy}, 16'h0000);
      repeat (3) @(posedge clk);
    end
  endtask
  task end_of_test;
    begin
      if (errors == 0 && check_count > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  initial begin
    #200000;
    errors = errors + 1;
    end_of_test;
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    load(9'h0FF);
    chk({7'h00, aout}, 16'h00FF);
    for (i = 15; i >= 0; i = i - 1) pulse(1, 1, i[0] ^ i[2]);
    request(0);
    load(9'h0FE);
    rd(1, 16'hFFFF);
    pulse(0, 0, 0);
    chk({7'h00, aout}, 16'h00FF);
    rd(0, 16'h5A5A);
    rd(1, 16'h5A5A);
    @(posedge clk) tsel <= 1'b1;
    taddr <= 9'h0FF;
    twr <= 1'b1;
    twd <= 16'h0FF0;
    @(posedge clk) twr <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk(trd, 16'h0A50);
    tsel <= 1'b0;
    request(1);
    rd(1, 16'hFFFF);
    @(posedge clk) #1 q = dosc;
    i = 0;
    for (n = 0; n < 240; n = n + 1) begin
      @(posedge clk) #1 i = i + (dosc !== q);
      q = dosc;
    end
    chk(i[15:0], 16'h0014);
    end_of_test;
  end
endmodule

// ===== ufsp_properties.sv
// Port checker for the user flash serial port, bound to the top module.
// Assumes CE stays high and requests are held until busy falls.
`timescale 1ns/1ps
module ufsp_props #(parameter AW = 9) (
  input wire          CLOCK,
  input wire          RST,
  input wire          ADDRESS_SHIFT_SELECT,
  input wire          ADDRESS_SHIFT_CLOCK,
  input wire          ADDRESS_IN,
  input wire          PROGRAM,
  input wire          ERASE,
  input wire          BUSY,
  input wire [AW-1:0] ADDRESS_OUT,
  input wire          DIVIDED_OSCILLATOR_OUT
);
  wire idle = !BUSY && !PROGRAM && !ERASE;
  wire osc  = DIVIDED_OSCILLATOR_OUT;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  sequence s_hi; osc[*8] ##[1:8] !osc; endsequence
  sequence s_lo; !osc[*8] ##[1:8] osc; endsequence
  a_busy_start: assert property (($rose(PROGRAM) || $rose(ERASE)) && !BUSY |-> ##[1:2] BUSY)
    else $error("busy did not follow request");
  a_busy_ends: assert property ($rose(BUSY) |-> ##[1:1000] !BUSY)
    else $error("busy never fell");
  a_busy_holds: assert property ($rose(BUSY) |-> BUSY[*8])
    else $error("busy too short");
  a_addr_step: assert property ($rose(ADDRESS_SHIFT_CLOCK) && !ADDRESS_SHIFT_SELECT && idle
    |=> ##1 ADDRESS_OUT == $past(ADDRESS_OUT, 2) + 1'b1) else $error("no increment");
  a_addr_shift: assert property ($rose(ADDRESS_SHIFT_CLOCK) && ADDRESS_SHIFT_SELECT && idle
    |=> ##1 ADDRESS_OUT == {$past(ADDRESS_OUT[AW-2:0], 2), $past(ADDRESS_IN, 2)})
    else $error("bad address shift");
  a_busy_refuse: assert property ($rose(ADDRESS_SHIFT_CLOCK) && BUSY |=> ##1 $stable(ADDRESS_OUT))
    else $error("shift taken while busy");
  a_osc_high: assert property ($rose(osc) |-> s_hi)
    else $error("oscillator high phase wrong");
  a_osc_low: assert property ($fell(osc) |-> s_lo)
    else $error("oscillator low phase wrong");
endmodule
bind user_flash_serial_port ufsp_props #(.AW(AW)) chk (.CLOCK, .RST, .ADDRESS_SHIFT_SELECT,
  .ADDRESS_SHIFT_CLOCK, .ADDRESS_IN, .PROGRAM, .ERASE, .BUSY, .ADDRESS_OUT,
  .DIVIDED_OSCILLATOR_OUT);

// ===== user_flash_serial_port.v
// User flash block as seen from the logic array: serial address and data,
// program and erase with a busy flag, and a divided oscillator output.
// Assumes all inputs synchronous to CLOCK; the shift clock is sampled and edge detected.
`timescale 1ns/1ps
`include "flash_port_defs.vh"
module user_flash_serial_port #(
  parameter AW          = `ADDR_WIDTH,
  parameter DW          = `DATA_WIDTH,
  parameter WORDS       = `WORD_COUNT,
  parameter PROG_CYCLES = `PROG_CYCLES,
  parameter ERASE_CYCLES = `ERASE_CYCLES
) (
  input  wire          CLOCK,
  input  wire          RST,
  input  wire          CE,
  input  wire          ADDRESS_SHIFT_SELECT,
  input  wire          ADDRESS_SHIFT_CLOCK,
  input  wire          ADDRESS_IN,
  input  wire          DATA_SHIFT_CLOCK,
  input  wire          DATA_SHIFT_SELECT,
  input  wire          DATA_IN,
  input  wire          PROGRAM,
  input  wire          ERASE,
  input  wire          TEST_PORT_SELECT,
  input  wire          TEST_PORT_WRITE,
  input  wire [AW-1:0] TEST_PORT_ADDRESS,
  input  wire [DW-1:0] TEST_PORT_WDATA,
  output reg  [DW-1:0] TEST_PORT_RDATA,
  output reg           DATA_OUT,
  output reg           BUSY,
  output reg  [AW-1:0] ADDRESS_OUT,
  output reg           DIVIDED_OSCILLATOR_OUT
);
  localparam ST_IDLE  = 4'b0001;
  localparam ST_PROG  = 4'b0010;
  localparam ST_ERASE = 4'b0100;
  localparam ST_DONE  = 4'b1000;

  localparam TICK_CYCLES = `OSC_HALF_CYCLES / 2;
  localparam PROG_TICKS  = PROG_CYCLES / TICK_CYCLES;
  localparam ERASE_TICKS = ERASE_CYCLES / TICK_CYCLES;

  reg [DW-1:0] mem [0:WORDS-1];
  reg [AW-1:0] addr_reg;
  reg [DW-1:0] data_reg;
  reg [3:0]    state_reg;
  reg [15:0]   count_reg;
  reg [AW:0]   erase_idx_reg;
  wire         osc_tick;
  wire         osc_div;
  wire [1:0]   shift_clk_pin;
  wire [1:0]   shift_clk_rise;
  wire         aclk_rise;
  wire         dclk_rise;
  integer      i;
  genvar       g;

  // Address step shared by the address and the data register
  function [AW-1:0] next_address;
    input [AW-1:0] a;
    begin
      next_address = a + {{(AW-1){1'b0}}, 1'b1};
    end
  endfunction

  // Shift clocks and test-port writes are honoured only in this state
  function in_idle;
    input [3:0] st;
    begin
      in_idle = (st == ST_IDLE);
    end
  endfunction

  assign shift_clk_pin = {DATA_SHIFT_CLOCK, ADDRESS_SHIFT_CLOCK};
  assign aclk_rise     = shift_clk_rise[0];
  assign dclk_rise     = shift_clk_rise[1];

  osc_divider #(
    .HALF_CYCLES (`OSC_HALF_CYCLES)
  ) u_osc (
    .clk      (CLOCK),
    .rst      (RST),
    .ce       (CE),
    .osc_tick (osc_tick),
    .div_out  (osc_div)
  );

  // Fixed rate output, no frequency setting exists
  always @(posedge CLOCK) begin
    if (RST)
      DIVIDED_OSCILLATOR_OUT <= 1'b0;
    else if (CE)
      DIVIDED_OSCILLATOR_OUT <= osc_div;
  end

  // Interface inputs are plain synchronous levels, from any global line or routing
  // One edge detector per shift clock, resting low like the idle pin
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_edge
      reg prev_reg;
      always @(posedge CLOCK) begin
        if (RST)
          prev_reg <= 1'b0;
        else if (CE)
          prev_reg <= shift_clk_pin[g];
      end
      assign shift_clk_rise[g] = shift_clk_pin[g] & ~prev_reg;
    end
  endgenerate

  // Address register: serial load or auto-increment
  always @(posedge CLOCK) begin
    if (RST) begin
      addr_reg    <= {AW{1'b0}};
      ADDRESS_OUT <= {AW{1'b0}};
    end else if (CE) begin
      if (aclk_rise && in_idle(state_reg)) begin
        if (ADDRESS_SHIFT_SELECT)
          addr_reg <= {addr_reg[AW-2:0], ADDRESS_IN};
        else
          addr_reg <= next_address(addr_reg);
      end
      ADDRESS_OUT <= addr_reg;
    end
  end

  // Data register: parallel load from array on a read, else shift
  always @(posedge CLOCK) begin
    if (RST) begin
      data_reg <= {DW{1'b0}};
      DATA_OUT <= 1'b0;
    end else if (CE) begin
      // A stream step preloads the next word so it is ready with the new address
      if (aclk_rise && !ADDRESS_SHIFT_SELECT && in_idle(state_reg))
        data_reg <= mem[next_address(addr_reg)];
      else if (dclk_rise && in_idle(state_reg)) begin
        if (DATA_SHIFT_SELECT)
          data_reg <= {data_reg[DW-2:0], DATA_IN};
        else
          data_reg <= mem[addr_reg];
      end
      DATA_OUT <= data_reg[DW-1];
    end
  end

  // Internal program and erase sequencer, paced by the oscillator
  always @(posedge CLOCK) begin
    if (RST) begin
      state_reg     <= ST_IDLE;
      count_reg     <= 16'h0000;
      erase_idx_reg <= {(AW+1){1'b0}};
      BUSY          <= 1'b0;
    end else if (CE) begin
      case (state_reg)
        ST_IDLE: begin
          count_reg <= 16'h0000;
          if (PROGRAM) begin
            state_reg <= ST_PROG;
            BUSY      <= 1'b1;
          end else if (ERASE) begin
            state_reg     <= ST_ERASE;
            erase_idx_reg <= {(AW+1){1'b0}};
            BUSY          <= 1'b1;
          end
        end
        ST_PROG: begin
          if (osc_tick)
            count_reg <= count_reg + 16'h0001;
          if (count_reg >= PROG_TICKS[15:0]) begin
            // Flash cells only clear bits, so a program ANDs into the cell
            mem[addr_reg] <= mem[addr_reg] & data_reg;
            state_reg     <= ST_DONE;
            BUSY          <= 1'b0;
          end
        end
        ST_ERASE: begin
          if (osc_tick)
            count_reg <= count_reg + 16'h0001;
          if (erase_idx_reg < WORDS[AW:0]) begin
            mem[erase_idx_reg[AW-1:0]] <= `ERASED_WORD;
            erase_idx_reg <= erase_idx_reg + {{AW{1'b0}}, 1'b1};
          end
          if (count_reg >= ERASE_TICKS[15:0]
              && erase_idx_reg >= WORDS[AW:0]) begin
            state_reg <= ST_DONE;
            BUSY      <= 1'b0;
          end
        end
        ST_DONE: begin
          if (!PROGRAM && !ERASE)
            state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
      if (TEST_PORT_SELECT && in_idle(state_reg) && TEST_PORT_WRITE)
        mem[TEST_PORT_ADDRESS] <= mem[TEST_PORT_ADDRESS] & TEST_PORT_WDATA;
    end
  end

  // Test-port read path; test-port erase timing is the port controller's job
  always @(posedge CLOCK) begin
    if (RST)
      TEST_PORT_RDATA <= {DW{1'b0}};
    else if (CE && TEST_PORT_SELECT)
      TEST_PORT_RDATA <= mem[TEST_PORT_ADDRESS];
  end

  initial begin
    for (i = 0; i < WORDS; i = i + 1)
      mem[i] = `ERASED_WORD;
  end
endmodule
